// ### tic_ctrl.sv
/*
  Trap and interrupt controller: trap detection and conflict reset,
  interrupt flag sampling and priority arbitration, frame push/pop,
  vector table select, shadow context and external edge requests.
  Assumes core strobes are one-cycle pulses synchronous to sys_clk_i.
*/
// Local design decisions: the register offsets and register access over AXI4-Lite.
// Functional notes
// - Stack pointer above limit raises stack trap
// - Stack pointer below 0x0800 raises stack trap
// - Oscillator failure raises oscillator trap
// - Levels 8-11 soft, math trap level 11
// - Levels 12-15 hard: address, stack, oscillator
// - Hard trap blocks execution until acknowledged
// - Lower hard trap under higher one conflicts
// - Conflict resets device, sets bit 15 flag
// - Simultaneous traps resolve by fixed priority
// - Event flags sampled every cycle, one pending
// - Only enabled requests may interrupt
// - Interrupt only above current processor priority
// - Push PC and status low byte
// - Load new priority, masking lower requests
// - Trap flag clear for interrupts, set traps
// - Return pops PC and status, restoring state
// - Alternate select uses alternate vector table
// - One-level shadow of flags and W0-W3
// - External requests edge sensitive, per polarity
// - Enabled request wakes from Sleep or Idle; code wakes only when a request is taken, above the current priority
// - Priority seven without trap masks all interrupts
module tic_ctrl
  import tic_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [7:0]        s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Event sources
  input  wire logic [IRQ_N-4:0]  irq_event_i,
  input  wire logic [2:0]        ext_request_i,
  input  wire logic              sp_load_i,
  input  wire logic [15:0]       sp_value_i,
  input  wire logic              osc_fail_i,
  input  wire logic              addr_err_i,
  input  wire logic              math_err_i,
  // Core handshake
  input  wire logic [23:0]       pc_i,
  input  wire logic              trap_ack_i,
  input  wire logic              return_from_isr_i,
  input  wire tic_frame_t        pop_frame_i,
  input  wire logic              sleep_i,
  input  wire logic              idle_i,
  input  wire logic              push_s_i,
  input  wire logic              pop_s_i,
  input  wire logic [63:0]       w_regs_i,
  // Core outputs
  output logic                   take_o,
  output logic [23:0]            vector_o,
  output logic                   frame_push_o,
  output tic_frame_t             frame_o,
  output logic                   stall_o,
  output logic                   wake_o,
  output logic                   self_reset_o,
  output logic [3:0]             cpu_priority_level_o,
  output logic [4:0]             status_flags_o,
  output logic [63:0]            shadow_w_o
);
  tic_state_t s;
  tic_state_t next_s;
  // Comb results kept visible for checks
  logic [IRQ_N-1:0] ev;
  logic [2:0]       ext_edge;
  logic [3:0]       t_ev;
  logic             conf;
  logic             take_trap;
  logic             take_irq;
  logic [2:0]       bp;
  logic [3:0]       cur4;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  // Register read decode; the top bit flags a mapped offset
  function automatic logic [32:0] rd_reg(input tic_state_t q,
                                         input logic [7:0] a);
    logic [31:0] r;
    logic        h;
    r = '0;
    h = 1'b1;
    unique case (a)
      OFS_IC1:
      begin
        r[IC1_NST]  = q.nst;
        r[IC1_MATH] = q.st_math;
        r[IC1_ADDR] = q.st_addr;
        r[IC1_STK]  = q.st_stk;
        r[IC1_OSC]  = q.st_osc;
      end
      OFS_IC2:
      begin
        r[IC2_ALT] = q.alt;
        r[2:0]     = q.ep;
      end
      OFS_FLG:   r[IRQ_N-1:0] = q.flg;
      OFS_ENA:   r[IRQ_N-1:0] = q.ena;
      OFS_PRI:   r[3*IRQ_N-1:0] = q.pri;
      OFS_STACK_LIMIT_REG: r[15:0] = q.stack_limit_reg;
      OFS_SR:    r[7:0] = {q.cpu_priority_level, q.sflags};
      OFS_CORE:  r[CORE_TRP] = q.trapf;
      OFS_RESET_CONTROL_REG:  r[RESET_CONTROL_REG_TRC] = q.reset_control_reg_tr;
      default:   h = 1'b0;
    endcase
    return {h, r};
  endfunction

  // All next-state logic; hardware sets are applied after software
  // writes so an event in the clearing cycle is never lost
  always_comb
  begin
    logic [31:0] old;
    logic [31:0] wv;
    logic [31:0] rd;
    logic        hit;
    logic [3:0]  tl;
    logic [1:0]  ti;
    logic [4:0]  slot;
    logic [2:0]  bi;
    logic [3:0]  hi;
    old  = '0;
    wv   = '0;
    rd   = '0;
    hit  = 1'b1;
    tl   = '0;
    ti   = '0;
    slot = '0;
    bi   = '0;
    hi   = '0;
    bp   = '0;
    ev   = '0;
    ext_edge = '0;
    t_ev = '0;
    conf = 1'b0;
    next_s = s;
    next_s.awr = 1'b0;
    next_s.arr = 1'b0;
    next_s.take = 1'b0;
    next_s.push = 1'b0;
    next_s.wake = 1'b0;
    next_s.rst_req = 1'b0;
    cur4 = {s.trapf, s.cpu_priority_level};
    take_trap = 1'b0;
    take_irq = 1'b0;

    // Read channel: ready for one cycle, data captured in that cycle
    if (!s.arr && !s.rv && s_axi_arvalid_i)
      next_s.arr = 1'b1;
    if (s.arr)
    begin
      {hit, rd} = rd_reg(s, s_axi_araddr_i);
      next_s.rv = 1'b1;
      next_s.rdata = rd;
      next_s.rresp = hit ? RESP_OK : RESP_ERR;
    end
    if (s.rv && s_axi_rready_i)
      next_s.rv = 1'b0;

    // Write channel: address and data are taken together, so the
    // master may offer them in either order and simply waits
    if (!s.awr && !s.bv && s_axi_awvalid_i && s_axi_wvalid_i)
      next_s.awr = 1'b1;
    if (s.awr)
    begin
      {hit, old} = rd_reg(s, s_axi_awaddr_i);
      wv = merge(old, s_axi_wdata_i, s_axi_wstrb_i);
      next_s.bv = 1'b1;
      next_s.bresp = hit ? RESP_OK : RESP_ERR;
      unique case (s_axi_awaddr_i)
        OFS_IC1:
        begin
          next_s.nst     = wv[IC1_NST];
          next_s.st_math = wv[IC1_MATH];
          next_s.st_addr = wv[IC1_ADDR];
          next_s.st_stk  = wv[IC1_STK];
          next_s.st_osc  = wv[IC1_OSC];
        end
        OFS_IC2:
        begin
          next_s.alt = wv[IC2_ALT];
          next_s.ep  = wv[2:0];
        end
        OFS_FLG:   next_s.flg = wv[IRQ_N-1:0];
        OFS_ENA:   next_s.ena = wv[IRQ_N-1:0];
        OFS_PRI:   next_s.pri = wv[3*IRQ_N-1:0];
        OFS_STACK_LIMIT_REG: next_s.stack_limit_reg = wv[15:0];
        OFS_SR:
        begin
          next_s.cpu_priority_level    = wv[7:5];
          next_s.sflags = wv[4:0];
        end
        OFS_RESET_CONTROL_REG:  next_s.reset_control_reg_tr = wv[RESET_CONTROL_REG_TRC];
        // Trap flag is hardware owned; core control is read only
        default:   ;
      endcase
    end
    if (s.bv && s_axi_bready_i)
      next_s.bv = 1'b0;

    // External pins: polarity bit low picks rising edge, high falling
    for (int i = 0; i < 3; i++)
      ext_edge[i] = s.ep[i] ? (s.ext_q[i] && !ext_request_i[i])
                            : (!s.ext_q[i] && ext_request_i[i]);
    next_s.ext_q = ext_request_i;
    ev = {ext_edge, irq_event_i};
    next_s.flg = next_s.flg | ev;

    // Trap sources; status bits stay set until software clears them
    t_ev[0] = math_err_i;
    t_ev[1] = addr_err_i;
    t_ev[2] = sp_load_i && (sp_value_i > s.stack_limit_reg);
    t_ev[2] = t_ev[2] || (sp_load_i && sp_value_i < STK_FLOOR);
    t_ev[3] = osc_fail_i;
    if (t_ev[0])
      next_s.st_math = 1'b1;
    if (t_ev[1])
      next_s.st_addr = 1'b1;
    if (t_ev[2])
      next_s.st_stk = 1'b1;
    if (t_ev[3])
      next_s.st_osc = 1'b1;

    // Highest hard level already pending or in service
    if (s.trapf && cur4 >= LVL_HARD)
      hi = cur4;
    for (int i = 1; i < 4; i++)
      if (s.tpend[i] && (LVL_SOFT + 4'(i)) > hi)
        hi = LVL_SOFT + 4'(i);
    // A new hard trap below that level cannot be nested safely
    for (int i = 1; i < 4; i++)
      if (t_ev[i] && (LVL_SOFT + 4'(i)) < hi)
        conf = 1'b1;

    // Fixed priority: the highest pending trap wins, others wait
    for (int i = 0; i < 4; i++)
      if (s.tpend[i])
      begin
        ti = 2'(i);
        tl = LVL_SOFT + 4'(i);
      end
    take_trap = (s.tpend != 4'h0) && (tl > cur4);

    // Interrupt arbitration; equal priorities go to the lower index
    for (int i = 0; i < IRQ_N; i++)
      if (s.flg[i] && s.ena[i] && s.pri[3*i +: 3] > bp)
      begin
        bp = s.pri[3*i +: 3];
        bi = 3'(i);
      end
    // Level seven leaves nothing above it, so it masks all requests
    take_irq = !take_trap && (bp != 3'h0) && ({1'b0, bp} > cur4);
    if (s.nst && s.isr_act)
      take_irq = 1'b0;

    // Acknowledge releases the core; a later take may stall it again
    if (trap_ack_i)
      next_s.hard_wait = 1'b0;

    // Return restores the stacked priority and flags
    if (return_from_isr_i)
    begin
      next_s.cpu_priority_level     = pop_frame_i.status_low_byte[7:5];
      next_s.sflags  = pop_frame_i.status_low_byte[4:0];
      next_s.trapf   = pop_frame_i.trap_priority_flag;
      next_s.isr_act = (pop_frame_i.status_low_byte[7:5] != 3'h0) && !pop_frame_i.trap_priority_flag;
    end

    // Vectoring: push the frame, then raise the priority
    if (take_trap || take_irq)
    begin
      next_s.take = 1'b1;
      next_s.push = 1'b1;
      next_s.frame.pc   = pc_i;
      next_s.frame.status_low_byte  = {s.cpu_priority_level, s.sflags};
      next_s.frame.trap_priority_flag = s.trapf;
      if (take_trap)
        slot = {1'b0, tl - 4'h8};
      else
        slot = TRAP_SLOTS + {2'b00, bi};
      next_s.vec = VEC_BASE + {19'h0, slot} + (s.alt ? ALT_OFS : 24'h0);
      next_s.wake = sleep_i || idle_i;
    end
    if (take_trap)
    begin
      next_s.trapf = 1'b1;
      next_s.cpu_priority_level = tl[2:0];
      next_s.tpend[ti] = 1'b0;
      if (tl >= LVL_HARD)
        next_s.hard_wait = 1'b1;
    end
    if (take_irq)
    begin
      next_s.trapf = 1'b0;
      next_s.cpu_priority_level = bp;
      next_s.isr_act = 1'b1;
    end
    // New events after the clear so a repeat in that cycle survives
    next_s.tpend = next_s.tpend | t_ev;

    // Shadow context, one level deep
    if (push_s_i)
    begin
      next_s.shadow.flags = s.sflags;
      next_s.shadow.w = w_regs_i;
    end
    if (pop_s_i)
    begin
      next_s.sflags = s.shadow.flags;
      next_s.shw = s.shadow.w;
    end

    // Conflict: drop pending and in-service trap state, keep trap status bits, and ask the system for a reset
    if (conf)
    begin
      next_s.rst_req = 1'b1;
      next_s.reset_control_reg_tr = 1'b1;
      next_s.tpend = '0;
      next_s.hard_wait = 1'b0;
      next_s.trapf = 1'b0;
      next_s.cpu_priority_level = '0;
      next_s.isr_act = 1'b0;
      next_s.take = 1'b0;
      next_s.push = 1'b0;
    end

    // Reset; pins start at their present level so no false edge
    if (rst_i)
    begin
      next_s = '0;
      next_s.ext_q = ext_request_i;
    end
  end

  // State register; the enable freezes everything except reset
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || ce_i)
      s <= next_s;
  end

  // Outputs come straight from the state flops
  assign s_axi_awready_o      = s.awr;
  assign s_axi_wready_o       = s.awr;
  assign s_axi_bvalid_o       = s.bv;
  assign s_axi_bresp_o        = s.bresp;
  assign s_axi_arready_o      = s.arr;
  assign s_axi_rvalid_o       = s.rv;
  assign s_axi_rdata_o        = s.rdata;
  assign s_axi_rresp_o        = s.rresp;
  assign take_o               = s.take;
  assign vector_o             = s.vec;
  assign frame_push_o         = s.push;
  assign frame_o              = s.frame;
  assign stall_o              = s.hard_wait;
  assign wake_o               = s.wake;
  assign self_reset_o         = s.rst_req;
  assign cpu_priority_level_o = {s.trapf, s.cpu_priority_level};
  assign status_flags_o       = s.sflags;
  assign shadow_w_o           = s.shw;

  // Stack bounds must leave the stack status set
  chk_stack_over:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ce_i && sp_load_i && sp_value_i > s.stack_limit_reg |=> s.st_stk)
    else $error("stack overflow not flagged");
  chk_stack_under:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ce_i && sp_load_i && sp_value_i < STK_FLOOR |=> s.st_stk)
    else $error("stack underflow not flagged");
  // Oscillator loss is recorded
  chk_osc_trap:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ce_i && osc_fail_i |=> s.st_osc)
    else $error("oscillator fail not flagged");
  // The top hard trap stalls the core
  chk_hard_stall:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ce_i && take_trap && s.tpend[3] && !conf |=> s.hard_wait && s.trapf)
    else $error("hard trap did not stall");
  // The stall holds until acknowledged
  chk_stall_hold:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ce_i && s.hard_wait && !trap_ack_i && !conf |=> s.hard_wait)
    else $error("stall dropped without acknowledge");
  // Conflict raises the reset and its status flag
  chk_conflict_rst:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ce_i && conf |=> s.rst_req && s.reset_control_reg_tr)
    else $error("conflict did not reset");
  // Only an enabled pending request is taken
  chk_irq_enable:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      take_irq |-> (s.flg & s.ena) != '0)
    else $error("disabled request taken");
  // Interrupt raises priority with the trap flag clear
  chk_irq_level:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ce_i && take_irq |=> s.take && !s.trapf && s.cpu_priority_level == $past(bp))
    else $error("interrupt priority not loaded");
  // Level seven outside traps masks every request
  chk_mask_seven:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !s.trapf && s.cpu_priority_level == 3'h7 |-> !take_irq)
    else $error("request taken at level seven");
endmodule

// ### tic_pkg.sv
/*
  Shared constants and types for the trap and interrupt controller.
  Assumes one 50 MHz instruction-cycle clock and an AXI4-Lite master.
*/
package tic_pkg;
  localparam int IRQ_N = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_IC1   = 8'h00;
  localparam logic [7:0] OFS_IC2   = 8'h04;
  localparam logic [7:0] OFS_FLG   = 8'h08;
  localparam logic [7:0] OFS_ENA   = 8'h0c;
  localparam logic [7:0] OFS_PRI   = 8'h10;
  localparam logic [7:0] OFS_STACK_LIMIT_REG = 8'h14;
  localparam logic [7:0] OFS_SR    = 8'h18;
  localparam logic [7:0] OFS_CORE  = 8'h1c;
  localparam logic [7:0] OFS_RESET_CONTROL_REG  = 8'h20;
  // Field positions
  localparam int IC1_NST  = 15;
  localparam int IC1_MATH = 4;
  localparam int IC1_ADDR = 3;
  localparam int IC1_STK  = 2;
  localparam int IC1_OSC  = 1;
  localparam int IC2_ALT  = 15;
  localparam int CORE_TRP = 3;
  localparam int RESET_CONTROL_REG_TRC = 15;
  // Trap levels; pending bit i holds level LVL_SOFT+i
  localparam logic [3:0] LVL_SOFT = 4'hb;
  localparam logic [3:0] LVL_HARD = 4'hc;
  localparam logic [15:0] STK_FLOOR = 16'h0800;
  // Vector tables, in program words
  localparam logic [23:0] VEC_BASE = 24'h000004;
  localparam logic [23:0] ALT_OFS  = 24'h000040;
  localparam logic [4:0]  TRAP_SLOTS = 5'h08;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef struct packed {
    logic [23:0] pc;
    logic [7:0]  status_low_byte;
    logic        trap_priority_flag;
  } tic_frame_t;

  typedef struct packed {
    logic [4:0]  flags;
    logic [63:0] w;
  } tic_shadow_t;

  typedef struct packed {
    logic        awr;
    logic        bv;
    logic [1:0]  bresp;
    logic        arr;
    logic        rv;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        nst;
    logic        st_math;
    logic        st_addr;
    logic        st_stk;
    logic        st_osc;
    logic        alt;
    logic [2:0]  ep;
    logic [IRQ_N-1:0] flg;
    logic [IRQ_N-1:0] ena;
    logic [3*IRQ_N-1:0] pri;
    logic [15:0] stack_limit_reg;
    logic [2:0]  cpu_priority_level;
    logic [4:0]  sflags;
    logic        trapf;
    logic        reset_control_reg_tr;
    logic [3:0]  tpend;
    logic        hard_wait;
    logic        isr_act;
    logic [2:0]  ext_q;
    logic        take;
    logic [23:0] vec;
    logic        push;
    tic_frame_t  frame;
    logic        wake;
    logic        rst_req;
    tic_shadow_t shadow;
    logic [63:0] shw;
  } tic_state_t;
endpackage

// ### tic_core_model.sv
/*
  Processor core stand-in for the trap and interrupt controller.
  Assumes controller outputs are synchronous to sys_clk_i.
*/
module tic_core_model
  import tic_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Controller side
  input  wire logic       ack_en_i,
  input  wire logic       stall_i,
  input  wire logic       frame_push_i,
  input  wire tic_frame_t frame_i,
  output logic            trap_ack_o,
  output tic_frame_t      pop_frame_o
);
  logic [1:0] cnt;
  // Ack a hard trap after a short delay; a slow core must still be honoured
  always_ff @(posedge sys_clk_i)
  begin
    cnt <= (stall_i && !rst_i) ? cnt + 2'h1 : 2'h0;
    trap_ack_o <= ack_en_i && stall_i && (cnt == 2'h2);
    if (frame_push_i)
      pop_frame_o <= frame_i;
  end
endmodule

// ### tb_top.sv
/*
  Bench for the trap and interrupt controller over AXI4-Lite.
  Assumes the core model answers traps and keeps the pushed frame.
*/
module tb_top
  import tic_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic spl = 1'b0, osc = 1'b0, adr = 1'b0, mth = 1'b0, ret = 1'b0, ackd = 1'b1, psh = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [4:0] ev = 5'h00;
  logic [2:0] ext = 3'h0;
  logic [15:0] spv = 16'h1000;
  logic [63:0] wreg = 64'h0;
  logic awrdy, wrdy, bval, arrdy, rval, ack, take, push, stl, srst;
  logic [1:0] br, rr;
  logic [3:0] cpu_priority_level;
  tic_frame_t fr, pfr;
  int err_count = 0, checks_done = 0, takes = 0, rsts = 0, t0;
  tic_ctrl u_dut (.sys_clk_i(clk), .rst_i(rst), .ce_i(1'b1),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bval), .s_axi_bready_i(brdy),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rval), .s_axi_rready_i(rrdy),
    .irq_event_i(ev), .ext_request_i(ext), .sp_load_i(spl), .sp_value_i(spv),
    .osc_fail_i(osc), .addr_err_i(adr), .math_err_i(mth), .pc_i(24'h000123),
    .trap_ack_i(ack), .return_from_isr_i(ret), .pop_frame_i(pfr), .sleep_i(1'b0),
    .idle_i(1'b0), .push_s_i(psh), .pop_s_i(psh), .w_regs_i(wreg), .take_o(take),
    .vector_o(), .frame_push_o(push), .frame_o(fr), .stall_o(stl), .wake_o(),
    .self_reset_o(srst), .cpu_priority_level_o(cpu_priority_level), .status_flags_o(), .shadow_w_o());
  tic_core_model u_core (.sys_clk_i(clk), .rst_i(rst), .ack_en_i(ackd), .stall_i(stl),
    .frame_push_i(push), .frame_i(fr), .trap_ack_o(ack), .pop_frame_o(pfr));
  // Clock and counts of taken requests and self resets
  initial
  begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (take) takes <= takes + 1;
    if (srst) rsts <= rsts + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // A bounded wait that ran out ends the run
  task automatic lim(input int k);
    if (k >= 60)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      test_done();
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (k = 0; k < 60; k++)
    begin
      @(posedge clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bval) break;
    end
    brdy <= 1'b0;
    lim(k);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] re);
    int k;
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (k = 0; k < 60; k++)
    begin
      @(posedge clk);
      if (arrdy) arv <= 1'b0;
      if (rval) break;
    end
    rrdy <= 1'b0;
    lim(k);
    chk(rd & m, e);
    chk({30'h0, rr}, {30'h0, re});
  endtask
  // Pulse a strobe for one cycle, then let the controller settle
  // 0 stack load, 1 oscillator fail, 2 return, 3 request event 0
  task automatic pulse(input int w);
    if (w == 0) spl <= 1'b1;
    else if (w == 1) osc <= 1'b1;
    else if (w == 2) ret <= 1'b1;
    else ev <= 5'h01;
    @(posedge clk);
    spl <= 1'b0;
    osc <= 1'b0;
    ret <= 1'b0;
    ev <= 5'h00;
    repeat (8) @(posedge clk);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(OFS_IC1, 32'hffffffff, 32'h0, RESP_OK);
    rdc(8'h3c, 32'h0, 32'h0, RESP_ERR);
    // Stack bounds: the floor value passes, two beyond either bound traps
    wr(OFS_STACK_LIMIT_REG, 32'h1000);
    spv <= 16'h0800;
    pulse(0);
    pulse(0);
    rdc(OFS_IC1, 32'h4, 32'h0, RESP_OK);
    spv <= 16'h1002;
    pulse(0);
    rdc(OFS_IC1, 32'h4, 32'h4, RESP_OK);
    pulse(2);
    wr(OFS_IC1, 32'h0);
    spv <= 16'h07fe;
    pulse(0);
    rdc(OFS_IC1, 32'h4, 32'h4, RESP_OK);
    chk({28'h0, cpu_priority_level}, 32'hd);
    pulse(2);
    wr(OFS_IC1, 32'h0);
    // Disabled request waits, enabling it lets it in at its level
    wr(OFS_PRI, 32'h00b6db6d);
    t0 = takes;
    pulse(3);
    chk(takes - t0, 0);
    wr(OFS_ENA, 32'hff);
    repeat (10) @(posedge clk);
    chk(takes - t0, 1);
    chk({28'h0, cpu_priority_level}, 32'h5);
    chk({31'h0, pfr.trap_priority_flag}, 32'h0);
    wr(OFS_FLG, 32'h0);
    pulse(2);
    chk({28'h0, cpu_priority_level}, 32'h0);
    // External pin 0 set to falling edge: rising is ignored
    wr(OFS_IC2, 32'h1);
    ext <= 3'h1;
    repeat (3) @(posedge clk);
    rdc(OFS_FLG, 32'h20, 32'h0, RESP_OK);
    ext <= 3'h0;
    repeat (3) @(posedge clk);
    rdc(OFS_FLG, 32'h20, 32'h20, RESP_OK);
    // Stack trap arriving under an unanswered oscillator trap
    ackd <= 1'b0;
    pulse(1);
    rdc(OFS_IC1, 32'h2, 32'h2, RESP_OK);
    chk({31'h0, stl}, 32'h1);
    spv <= 16'h0100;
    pulse(0);
    rdc(OFS_RESET_CONTROL_REG, 32'h8000, 32'h8000, RESP_OK);
    chk({31'h0, stl}, 32'h0);
    chk(rsts, 1);
    test_done();
  end
endmodule
